/* rtl/pot_link_if.sv */
`timescale 1ns/1ps
// Purpose: open-drain two-wire link between master and target
// Assumes: a pull-up; a line is low while any party enables its driver
// Notes:   drivers only ever pull low
interface pot_link_if;
	logic scl_oe;      // master pulls clock low
	logic sda_m_oe;    // master pulls data low
	logic sda_t_oe;    // target pulls data low
	logic scl;
	logic sda;
	assign scl = ~scl_oe;
	assign sda = ~(sda_m_oe | sda_t_oe);
	modport master (output scl_oe, output sda_m_oe, input scl, input sda);
	modport target (output sda_t_oe, input scl, input sda);
endinterface

/* rtl/pot_master.sv */
`timescale 1ns/1ps
// Purpose: two-wire master issuing one write or one read to the potentiometer target
// Assumes: user holds cmd fields stable while busy
// Notes:   clock made by a quarter-period divider; no clock stretching
module pot_master
	import pot_pkg::*;
(
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// link
	pot_link_if.master link,
	// user request
	input  wire logic       cmd_valid,
	input  wire logic       cmd_read,
	input  wire logic       cmd_addr_sel,
	input  wire logic       cmd_rs,
	input  wire logic       cmd_sd,
	input  wire logic [7:0] cmd_data,
	output logic            cmd_ready,
	// user answer
	output logic            done,
	output logic            nack_err,
	output logic [7:0]      rd_data
);
	typedef enum {M_IDLE, M_START, M_BIT, M_STOP} mstate_t;

	mstate_t    st_r, st_nxt;
	logic [7:0] div_r, div_nxt, rd_r, rd_nxt;
	logic [1:0] ph_r, ph_nxt, idx_r, idx_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic       scl_oe_r, scl_oe_nxt, sda_oe_r, sda_oe_nxt, err_r, err_nxt, done_r, done_nxt;
	logic [1:0] sda_s_r;
	logic       tick;
	logic [7:0] tx_cur;

	// byte to send at index i
	function automatic logic [7:0] tx_byte(input logic [1:0] i);
		case (i)
			2'h0:    tx_byte = {ADDR_FIXED, cmd_addr_sel, cmd_read};
			2'h1:    tx_byte = {1'b0, cmd_rs, cmd_sd, 5'h00};
			default: tx_byte = cmd_data;
		endcase
	endfunction

	assign tick   = (div_r == QTR_CNT);
	assign tx_cur = tx_byte(idx_r); // byte now on the wire

	// ------------------------------------------------------------
	// sequencer: four quarter phases per clock pulse
	// ------------------------------------------------------------
	always_comb begin
		st_nxt     = st_r;
		div_nxt    = tick ? 8'h00 : div_r + 8'h01;
		ph_nxt     = ph_r;
		idx_nxt    = idx_r;
		bit_nxt    = bit_r;
		scl_oe_nxt = scl_oe_r;
		sda_oe_nxt = sda_oe_r;
		rd_nxt     = rd_r;
		err_nxt    = err_r;
		done_nxt   = 1'b0;
		case (st_r)
			M_IDLE: if (cmd_valid) begin
				st_nxt  = M_START;
				ph_nxt  = '0;
				div_nxt = '0;
				err_nxt = 1'b0;
			end
			M_START: if (tick) begin // data falls while clock high
				ph_nxt = ph_r + 2'h1;
				if (ph_r == 2'h0) sda_oe_nxt = 1'b1;
				if (ph_r == 2'h1) scl_oe_nxt = 1'b1;
				if (ph_r == 2'h1) begin
					st_nxt  = M_BIT;
					ph_nxt  = '0;
					idx_nxt = '0;
					bit_nxt = '0;
				end
			end
			M_BIT: if (tick) begin
				ph_nxt = ph_r + 2'h1;
				case (ph_r)
					2'h0: begin // clock low: drive data
						if (bit_r < BITS_PER_BYTE)
							sda_oe_nxt = (cmd_read && idx_r != 2'h0) ? 1'b0 : ~tx_cur[3'(7 - bit_r)];
						else
							sda_oe_nxt = 1'b0; // ack slot; read byte gets nack
					end
					2'h1: scl_oe_nxt = 1'b0;
					2'h2: begin
						if (bit_r < BITS_PER_BYTE && cmd_read && idx_r != 2'h0)
							rd_nxt = {rd_r[6:0], sda_s_r[1]}; // line is stable mid-high
						if (bit_r == BITS_PER_BYTE && !(cmd_read && idx_r != 2'h0) && sda_s_r[1])
							err_nxt = 1'b1;
					end
					default: begin
						scl_oe_nxt = 1'b1;
						bit_nxt    = bit_r + 4'h1;
						if (bit_r == BITS_PER_BYTE) begin
							bit_nxt = '0;
							idx_nxt = (cmd_read && idx_r == 2'h0) ? 2'h2 : idx_r + 2'h1;
							if (idx_r == 2'h2 || err_r) // one instruction per transaction
								st_nxt = M_STOP;
						end
					end
				endcase
			end
			M_STOP: if (tick) begin // data low, clock high, data high
				ph_nxt = ph_r + 2'h1;
				if (ph_r == 2'h0) sda_oe_nxt = 1'b1;
				if (ph_r == 2'h1) scl_oe_nxt = 1'b0;
				if (ph_r == 2'h2) sda_oe_nxt = 1'b0;
				if (ph_r == 2'h3) begin
					st_nxt   = M_IDLE;
					done_nxt = 1'b1;
				end
			end
			default: st_nxt = M_IDLE;
		endcase
	end

	// registers; line sample is two-flop synchronised for the ack check
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r     <= M_IDLE;
			div_r    <= 8'h00;
			ph_r     <= 2'h0;
			idx_r    <= 2'h0;
			bit_r    <= 4'h0;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
			rd_r     <= 8'h00;
			err_r    <= 1'b0;
			done_r   <= 1'b0;
			sda_s_r  <= 2'h3;
		end else begin
			st_r     <= st_nxt;
			div_r    <= div_nxt;
			ph_r     <= ph_nxt;
			idx_r    <= idx_nxt;
			bit_r    <= bit_nxt;
			scl_oe_r <= scl_oe_nxt;
			sda_oe_r <= sda_oe_nxt;
			rd_r     <= rd_nxt;
			err_r    <= err_nxt;
			done_r   <= done_nxt;
			sda_s_r  <= {sda_s_r[0], link.sda};
		end
	end

	assign link.scl_oe   = scl_oe_r;
	assign link.sda_m_oe = sda_oe_r;
	assign cmd_ready     = (st_r == M_IDLE);
	assign done          = done_r;
	assign nack_err      = err_r;
	assign rd_data       = rd_r;
endmodule

/* rtl/pot_pkg.sv */
// Purpose: shared constants for the potentiometer two-wire target and its master
// Assumes: one 40 MHz system clock on both ends, link clock made by the master
package pot_pkg;
	// ------------------------------------------------------------
	// address and instruction layout
	// ------------------------------------------------------------
	localparam logic [5:0] ADDR_FIXED    = 6'h16; // 010110
	localparam int         BIT_RS        = 6;     // midscale_reset_bit
	localparam int         BIT_SD        = 5;     // shutdown_bit
	localparam logic [7:0] WIPER_MID     = 8'h80;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	// ------------------------------------------------------------
	// link timing (master divider)
	// ------------------------------------------------------------
	localparam int         SYS_HZ        = 40_000_000;
	localparam int         SCL_HZ        = 100_000;
	localparam int         QTR_CYC       = SYS_HZ / (SCL_HZ * 4); // quarter period, rounded down
	localparam logic [7:0] QTR_CNT       = 8'(QTR_CYC - 1);
endpackage

/* rtl/pot_target.sv */
`timescale 1ns/1ps
// Purpose: two-wire target of a 256-position potentiometer, wiper register and controls
// Assumes: link lines sampled by sys_clk through two flops each
// Notes:   the analog network is modelled only by its control outputs
module pot_target
	import pot_pkg::*;
(
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// link
	pot_link_if.target link,
	// straps and analog controls
	input  wire logic       addr_select_pin,
	output logic [7:0]      wiper_resistor_dac,
	output logic            term_a_open,
	output logic            wiper_to_b,
	output logic [7:0]      wiper_reg
);
	typedef enum {T_IDLE, T_ADDR, T_ACK, T_INSTR, T_WDATA, T_RDATA, T_RACK, T_IGNORE} tstate_t;

	logic [1:0] scl_s_r, sda_s_r, scl_s_nxt, sda_s_nxt, sel_s_r, sel_s_nxt;
	logic       scl_q_r, sda_q_r;
	tstate_t    st_r, st_nxt, after_r, after_nxt;
	logic [7:0] sh_r, sh_nxt, wiper_r, wiper_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic       oe_r, oe_nxt, sd_r, sd_nxt, rd_r, rd_nxt;
	logic       scl_rise, scl_fall, start_c, stop_c, scl_i, sda_i;

	// ------------------------------------------------------------
	// synchronisers and edge detection
	// ------------------------------------------------------------
	// second stage only is looked at; first stage guards metastability
	always_comb begin
		scl_s_nxt = {scl_s_r[0], link.scl};
		sda_s_nxt = {sda_s_r[0], link.sda};
		sel_s_nxt = {sel_s_r[0], addr_select_pin}; // strap is a pin, may move at any time
	end
	assign scl_i    = scl_s_r[1];
	assign sda_i    = sda_s_r[1];
	assign scl_rise = scl_i & ~scl_q_r;
	assign scl_fall = ~scl_i & scl_q_r;
	assign start_c  = scl_i & scl_q_r & sda_q_r & ~sda_i;
	assign stop_c   = scl_i & scl_q_r & ~sda_q_r & sda_i;

	// ------------------------------------------------------------
	// protocol engine
	// ------------------------------------------------------------
	always_comb begin
		st_nxt    = st_r;
		after_nxt = after_r;
		sh_nxt    = sh_r;
		cnt_nxt   = cnt_r;
		oe_nxt    = oe_r;
		wiper_nxt = wiper_r;
		sd_nxt    = sd_r;
		rd_nxt    = rd_r;
		if (start_c) begin // repeated start also lands here
			st_nxt  = T_ADDR;
			cnt_nxt = '0;
			oe_nxt  = 1'b0;
		end else if (stop_c) begin
			st_nxt = T_IDLE;
			oe_nxt = 1'b0;
		end else begin
			case (st_r)
				T_IDLE, T_IGNORE: oe_nxt = 1'b0;
				T_ADDR, T_INSTR, T_WDATA: begin
					if (scl_rise) begin // msb first
						sh_nxt  = {sh_r[6:0], sda_i};
						cnt_nxt = cnt_r + 4'h1;
					end
					if (scl_fall && cnt_r == BITS_PER_BYTE) begin
						cnt_nxt = '0;
						oe_nxt  = 1'b1; // ack on the ninth pulse; changed only with clock low
						st_nxt  = T_ACK;
						if (st_r == T_ADDR) begin
							if (sh_r[7:2] == ADDR_FIXED && sh_r[1] == sel_s_r[1]) begin
								rd_nxt    = sh_r[0];
								after_nxt = sh_r[0] ? T_RDATA : T_INSTR;
							end else begin
								oe_nxt = 1'b0;
								st_nxt = T_IGNORE;
							end
						end else if (st_r == T_INSTR) begin
							sd_nxt    = sh_r[BIT_SD];
							after_nxt = T_WDATA;
							if (sh_r[BIT_RS])
								wiper_nxt = WIPER_MID;
						end else begin
							wiper_nxt = sh_r; // every data byte loads
							after_nxt = T_WDATA;
						end
					end
				end
				T_ACK: if (scl_fall) begin // end of ninth pulse
					if (after_r == T_RDATA) begin
						sh_nxt  = wiper_r;
						oe_nxt  = ~wiper_r[7];
						cnt_nxt = 4'h1;
					end else
						oe_nxt = 1'b0;
					st_nxt = after_r;
				end
				T_RDATA: if (scl_fall) begin
					if (cnt_r == BITS_PER_BYTE) begin
						oe_nxt = 1'b0; // release for master ack
						st_nxt = T_RACK;
					end else begin
						sh_nxt  = {sh_r[6:0], 1'b0};
						oe_nxt  = ~sh_r[6];
						cnt_nxt = cnt_r + 4'h1;
					end
				end
				T_RACK: if (scl_rise) begin
					if (sda_i)
						st_nxt = T_IGNORE; // nack: wait for stop
					else begin
						st_nxt    = T_ACK; // next fall reloads wiper
						after_nxt = T_RDATA;
					end
				end
				default: st_nxt = T_IDLE;
			endcase
		end
	end

	// registers; wiper at midscale from reset
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			scl_s_r <= 2'h3;
			sda_s_r <= 2'h3;
			sel_s_r <= 2'h0;
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
			st_r    <= T_IDLE;
			after_r <= T_IDLE;
			sh_r    <= 8'h00;
			cnt_r   <= 4'h0;
			oe_r    <= 1'b0;
			wiper_r <= WIPER_MID;
			sd_r    <= 1'b0;
			rd_r    <= 1'b0;
		end else begin
			scl_s_r <= scl_s_nxt;
			sda_s_r <= sda_s_nxt;
			sel_s_r <= sel_s_nxt;
			scl_q_r <= scl_i;
			sda_q_r <= sda_i;
			st_r    <= st_nxt;
			after_r <= after_nxt;
			sh_r    <= sh_nxt;
			cnt_r   <= cnt_nxt;
			oe_r    <= oe_nxt;
			wiper_r <= wiper_nxt;
			sd_r    <= sd_nxt;
			rd_r    <= rd_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign link.sda_t_oe     = oe_r;
	assign wiper_reg         = wiper_r;
	assign wiper_resistor_dac = sd_r ? 8'h00 : wiper_r; // stored value kept
	assign term_a_open       = sd_r;
	assign wiper_to_b        = sd_r;
endmodule

/* tb/pot_link_asserts.sv */
`timescale 1ns/1ps
// Purpose: wire checks on the two-wire link
// Assumes: lines sampled on sys_clk
// Notes:   pulse count restarts at each start
module pot_link_asserts (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// link
	input wire logic scl_oe,
	input wire logic sda_m_oe,
	input wire logic sda_t_oe,
	input wire logic scl,
	input wire logic sda
);
	logic       scl_q_r, scl_q_nxt, sda_q_r, sda_q_nxt, rd_r, rd_nxt, start_ev, stop_ev;
	logic [7:0] cnt_r, cnt_nxt;
	// ------------------------------------------------
	// frame tracking
	// ------------------------------------------------
	// clock-high data edges bound frames; read bit taken at rise 8
	always_comb begin
		start_ev  = scl && scl_q_r && sda_q_r && !sda;
		stop_ev   = scl && scl_q_r && !sda_q_r && sda;
		scl_q_nxt = scl;
		sda_q_nxt = sda;
		cnt_nxt   = cnt_r;
		rd_nxt    = rd_r;
		if (start_ev)
			cnt_nxt = 8'h00;
		else if (scl && !scl_q_r)
			cnt_nxt = cnt_r + 8'h01;
		if (scl && !scl_q_r && cnt_r == 8'h07)
			rd_nxt = sda;
	end
	// lines idle high in reset
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
			rd_r    <= 1'b0;
			cnt_r   <= 8'h00;
		end else begin
			scl_q_r <= scl_q_nxt;
			sda_q_r <= sda_q_nxt;
			rd_r    <= rd_nxt;
			cnt_r   <= cnt_nxt;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	AST_TGT_RISE_LOW:
		assert property ($rose(sda_t_oe) |-> !scl) else $error("target pulled data with clock high");
	AST_TGT_FALL_LOW:
		assert property ($fell(sda_t_oe) |-> !scl) else $error("target freed data with clock high");
	AST_MST_HOLD_HIGH:
		assert property ((scl && $past(scl) && $changed(sda_m_oe)) |-> (cnt_r == 8'h00 || cnt_r % 9 == 1))
			else $error("master moved data inside a bit");
	AST_STOP_TENTH:
		assert property (stop_ev |-> (cnt_r % 9 == 1 && cnt_r > 8'h09)) else $error("stop off the tenth pulse");
	AST_ACK_SLOT:
		assert property ((scl && scl_q_r && sda_t_oe) |-> (cnt_r % 9 == 0 || (rd_r && cnt_r >= 8'h0A && cnt_r <= 8'h11)))
			else $error("target drove outside its slots");
	AST_QUIET_ADDR:
		assert property (sda_t_oe |-> cnt_r >= 8'h08) else $error("target drove during address");
	AST_READ_NACK:
		assert property ((rd_r && scl && scl_q_r && cnt_r == 8'h12) |-> sda) else $error("read not ended by nack");
	AST_SLOT_HELD:
		assert property ($rose(sda_t_oe) |-> sda_t_oe [*8]) else $error("target drive too short");
	AST_IDLE_RELEASE:
		assert property ($fell(rst) |-> !(scl_oe || sda_m_oe || sda_t_oe)) else $error("line held after reset");
endmodule

/* tb/pot_wiper_i2c_target_test.sv */
`timescale 1ns/1ps
// Purpose: master and target joined, checked against a wiper model
// Assumes: one transfer at a time
// Notes:   transfers are long at 100 kHz, so scenarios are few
module pot_wiper_i2c_target_test;
	logic       sys_clk = 1'b0;
	logic       rst = 1'b1;
	logic       addr_select_pin = 1'b0;
	logic       cmd_valid = 1'b0;
	logic       cmd_read = 1'b0;
	logic       cmd_addr_sel = 1'b0;
	logic       cmd_rs = 1'b0;
	logic       cmd_sd = 1'b0;
	logic [7:0] cmd_data = 8'h00;
	logic       cmd_ready, done, nack_err, term_a_open, wiper_to_b;
	logic [7:0] rd_data, wiper_resistor_dac, wiper_reg;
	int         n_fail = 0;
	int         checked = 0;
	int         wiper_m = 'h80;
	bit         sd_m = 1'b0;
	bit         seen_mid = 1'b0;
	pot_link_if link_bus ();
	// 40 MHz
	always #12.5 sys_clk = ~sys_clk;
	pot_master u_pot_master (.sys_clk(sys_clk), .rst(rst), .link(link_bus), .cmd_valid(cmd_valid),
		.cmd_read(cmd_read), .cmd_addr_sel(cmd_addr_sel), .cmd_rs(cmd_rs), .cmd_sd(cmd_sd),
		.cmd_data(cmd_data), .cmd_ready(cmd_ready), .done(done), .nack_err(nack_err), .rd_data(rd_data));
	pot_target u_pot_target (.sys_clk(sys_clk), .rst(rst), .link(link_bus), .addr_select_pin(addr_select_pin),
		.wiper_resistor_dac(wiper_resistor_dac), .term_a_open(term_a_open), .wiper_to_b(wiper_to_b),
		.wiper_reg(wiper_reg));
	pot_link_asserts u_pot_link_asserts (.sys_clk(sys_clk), .rst(rst), .scl_oe(link_bus.scl_oe),
		.sda_m_oe(link_bus.sda_m_oe), .sda_t_oe(link_bus.sda_t_oe), .scl(link_bus.scl), .sda(link_bus.sda));
	// midscale passes by before the data byte lands
	always @(posedge sys_clk)
		if (wiper_reg === 8'h80)
			seen_mid = 1'b1;
	// ------------------------------------------------
	// compare and finish
	// ------------------------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// one transfer, then model against every output
	task automatic xfer(input bit rd, input bit sel, input bit rs, input bit sd, input logic [7:0] d);
		int i;
		bit hit;
		hit = (sel == addr_select_pin);
		@(negedge sys_clk);
		cmd_read = rd;
		cmd_addr_sel = sel;
		cmd_rs = rs;
		cmd_sd = sd;
		cmd_data = d;
		cmd_valid = 1'b1;
		seen_mid = 1'b0;
		@(negedge sys_clk);
		cmd_valid = 1'b0;
		for (i = 0; i < 16000 && done !== 1'b1; i++)
			@(negedge sys_clk);
		check("done", {7'h00, done}, 8'h01);
		if (!rd && hit) begin
			if (rs)
				check("mid", {7'h00, seen_mid}, 8'h01);
			wiper_m = d;
			sd_m = sd;
		end
		check("nack", {7'h00, nack_err}, {7'h00, !hit});
		check("ready", {7'h00, cmd_ready}, 8'h01);
		if (rd)
			check("rd", rd_data, wiper_m[7:0]);
		check("reg", wiper_reg, wiper_m[7:0]);
		check("dac", wiper_resistor_dac, sd_m ? 8'h00 : wiper_m[7:0]);
		check("open", {7'h00, term_a_open}, {7'h00, sd_m});
		check("tob", {7'h00, wiper_to_b}, {7'h00, sd_m});
	endtask
	// ------------------------------------------------
	// scenarios
	// ------------------------------------------------
	initial begin
		void'($urandom(32'hBA28));
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
		rst = 1'b0;
		check("reset", wiper_reg, 8'h80);
		repeat (4) @(negedge sys_clk);
		xfer(0, 0, 0, 0, 8'($urandom) | 8'h01);
		xfer(1, 0, 0, 0, 8'h00);
		xfer(0, 0, 1, 0, 8'($urandom) | 8'h01);
		xfer(0, 0, 0, 1, 8'($urandom));
		xfer(1, 0, 0, 0, 8'h00);
		xfer(0, 0, 0, 0, 8'($urandom));
		addr_select_pin = 1'b1;
		xfer(0, 0, 0, 0, 8'($urandom));
		xfer(1, 1, 0, 0, 8'h00);
		wrap_up();
	end
	// hang guard, some margin beyond the expected run of about 73k cycles
	initial begin
		#(100_000 * 25);
		n_fail++;
		wrap_up();
	end
endmodule
